// file: mfirq_pkg.sv
`default_nettype none
package mfirq_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int unsigned NUM_GROUPS = 6;
  localparam int unsigned NUM_TIMERS = 4;
  localparam int unsigned NUM_SRC = 16;
  localparam int unsigned VEC_W = 3;
  localparam int unsigned ADDR_W = 12;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_GROUP_EN = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_GROUP_FLAG = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_SRC_FLAG = 12'h00c;
  localparam logic [ADDR_W-1:0] ADDR_SRC_EN = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_SRC_SET = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h018;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int unsigned CTRL_GIE_BIT = 0;
  localparam int unsigned STAT_REQ_BIT = 0;
  localparam int unsigned STAT_VEC_LSB = 1;
  localparam int unsigned STAT_HALT_BIT = 4;
  localparam int unsigned SRC_SERIAL = 0;
  localparam int unsigned SRC_EXT = 1;
  localparam int unsigned SRC_NVM = 2;
  localparam int unsigned SRC_LOWSUP = 3;
  localparam int unsigned SRC_TMR_BASE = 4;
  localparam int unsigned TMR_STRIDE = 3;
  localparam int unsigned TMR_P_OFS = 0;
  localparam int unsigned TMR_A_OFS = 1;
  localparam int unsigned TMR_B_OFS = 2;

  // Source bits that exist; only timer 0 is the enhanced type with a B match.
  localparam logic [NUM_SRC-1:0] SRC_IMPL = 16'h6dff;

  // Sources that feed each group.
  localparam logic [NUM_SRC-1:0] GROUP_MEMBERS [NUM_GROUPS] = '{
    16'h0003, 16'h000c, 16'h0070, 16'h0380, 16'h1c00, 16'he000
  };

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic RST_GIE = 1'b0;
  localparam logic [NUM_GROUPS-1:0] RST_GROUP_EN = 6'h00;
  localparam logic [NUM_GROUPS-1:0] RST_GROUP_FLAG = 6'h00;
  localparam logic [NUM_SRC-1:0] RST_SRC_EN = 16'h0000;
  localparam logic [NUM_SRC-1:0] RST_SRC_FLAG = 16'h0000;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic serial_byte_done;
    logic nvm_cycle_done;
    logic [NUM_TIMERS-1:0] tm_period_match;
    logic [NUM_TIMERS-1:0] tm_a_match;
    logic [NUM_TIMERS-1:0] tm_b_match;
  } mfirq_src_ev_t;

  typedef struct packed {
    logic stack_free;
    logic irq_ack;
    logic return_from_irq_instr_exec;
    logic ret_exec;
    logic halted;
  } mfirq_core_in_t;

  typedef struct packed {
    logic irq_req;
    logic [VEC_W-1:0] vector;
    logic push_pc;
    logic wakeup;
    logic wake_service;
    logic wake_resume_next;
  } mfirq_core_out_t;

endpackage
`default_nettype wire

// file: mfirq_flag_bank.sv
`default_nettype none
module mfirq_flag_bank #(
  parameter int unsigned W = 8,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] flags,
  output logic [W-1:0] rise
);

  logic [W-1:0] flags_q;

  // A set in the same cycle as a clear wins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= RST;
    end else begin
      flags_q <= (flags_q & ~clr) | set;
    end
  end

  assign flags = flags_q;
  assign rise = set & ~flags_q;

endmodule
`default_nettype wire

// file: mfirq_ctrl.sv
// Contract
// R1: Serial byte received or sent sets the serial request flag.
// R2: Vector only with global, source, group enables, pending request, free stack.
// R3: Service clears global enable and group flag, leaves source flag set.
// R4: Falling edge on peripheral pin sets external peripheral flag.
// R5: Memory read or write cycle end sets memory-cycle flag.
// R6: Supply falling below threshold sets low-supply flag.
// R7: Timers have period and A flags with enables; enhanced adds B.
// R8: Timer comparator match sets the matching timer flag.
// R9: In sleep or idle, any flag rising low to high wakes.
// R10: Enable bits never gate the wake-up path.
// R11: Software sets a flag high before halt to suppress its wake-up.
// R12: Flags hold until serviced or cleared; enables only block service.
// R13: Interrupt entry pushes only the program counter.
// R14: Interrupt return sets global enable; plain return leaves it clear.
// R15: Up to six group flags, each cleared when its group is serviced.
// R16: Software avoids calls inside service routines to save stack.
// R17: Software routes shared pin to peripheral interrupt function first.
// R18: Any member source setting its flag sets the group flag.
// R19: Disabled or stack-full wake resumes after halt; service comes later.
// R20: Simultaneous pending groups are served lowest number first.
`default_nettype none
module mfirq_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mfirq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic periph_irq_pin,
  input wire logic supply_low_det,
  input wire mfirq_pkg::mfirq_src_ev_t src_ev,
  input wire mfirq_pkg::mfirq_core_in_t core_in,
  output mfirq_pkg::mfirq_core_out_t core_out
);
  import mfirq_pkg::*;

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic global_irq_enable_q;
  logic [NUM_GROUPS-1:0] group_irq_en_q;
  logic [NUM_SRC-1:0] src_en_q;
  logic [NUM_SRC-1:0] src_flags;
  logic [NUM_SRC-1:0] src_rise;
  logic [NUM_GROUPS-1:0] group_req_flags_all;
  logic [NUM_GROUPS-1:0] group_rise;
  logic irq_req_q;
  logic [VEC_W-1:0] vector_q;
  logic push_pc_q;
  logic wake_q;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;

  always_comb begin
    case (paddr)
      ADDR_CTRL, ADDR_GROUP_EN, ADDR_GROUP_FLAG, ADDR_SRC_FLAG,
      ADDR_SRC_EN, ADDR_SRC_SET, ADDR_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign apb_wr = psel & penable & pwrite & addr_ok;
  assign apb_rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;
  logic lvd_s1_q;
  logic lvd_s2_q;
  logic lvd_s3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
    end else begin
      pin_s1_q <= periph_irq_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvd_s1_q <= 1'b0;
      lvd_s2_q <= 1'b0;
      lvd_s3_q <= 1'b0;
    end else begin
      lvd_s1_q <= supply_low_det;
      lvd_s2_q <= lvd_s1_q;
      lvd_s3_q <= lvd_s2_q;
    end
  end

  // ------------------------------------------------------------
  // Source flag events
  // ------------------------------------------------------------
  logic [NUM_SRC-1:0] src_set;
  logic [NUM_SRC-1:0] src_clr;

  always_comb begin
    src_set = '0;
    // R1: serial byte done
    src_set[SRC_SERIAL] = src_ev.serial_byte_done;
    // R4: falling pin edge
    src_set[SRC_EXT] = pin_s3_q & ~pin_s2_q;
    // R5: memory cycle end
    src_set[SRC_NVM] = src_ev.nvm_cycle_done;
    // R6: supply drops low
    src_set[SRC_LOWSUP] = lvd_s2_q & ~lvd_s3_q;
    for (int t = 0; t < NUM_TIMERS; t++) begin
      // R8: timer match events
      src_set[SRC_TMR_BASE + TMR_STRIDE * t + TMR_P_OFS] = src_ev.tm_period_match[t];
      src_set[SRC_TMR_BASE + TMR_STRIDE * t + TMR_A_OFS] = src_ev.tm_a_match[t];
      src_set[SRC_TMR_BASE + TMR_STRIDE * t + TMR_B_OFS] = src_ev.tm_b_match[t];
    end
    // R11: software may raise a flag itself
    if (apb_wr && paddr == ADDR_SRC_SET) begin
      src_set = src_set | pwdata[NUM_SRC-1:0];
    end
    // R7: absent B-match bits never exist
    src_set = src_set & SRC_IMPL;
  end

  // R3: only software clears a source flag
  assign src_clr = (apb_wr && paddr == ADDR_SRC_FLAG) ? pwdata[NUM_SRC-1:0] : '0;

  // R12: source flags stay set until cleared
  mfirq_flag_bank #(
    .W(NUM_SRC),
    .RST(RST_SRC_FLAG)
  ) u_src_flags (
    .clk(pclk),
    .rst_n(presetn),
    .set(src_set),
    .clr(src_clr),
    .flags(src_flags),
    .rise(src_rise)
  );

  // ------------------------------------------------------------
  // Group flags
  // ------------------------------------------------------------
  logic [NUM_GROUPS-1:0] group_set;
  logic [NUM_GROUPS-1:0] group_clr;
  logic [NUM_GROUPS-1:0] group_pend;
  logic [NUM_GROUPS-1:0] ack_onehot;

  always_comb begin
    group_set = '0;
    group_pend = '0;
    ack_onehot = '0;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      // R18: member event sets group
      group_set[g] = |(src_set & GROUP_MEMBERS[g]);
      // R2: all enables, request and stack
      group_pend[g] = group_req_flags_all[g] & group_irq_en_q[g] &
                      (|(src_flags & src_en_q & GROUP_MEMBERS[g])) &
                      global_irq_enable_q & core_in.stack_free;
    end
    // R15: serviced group flag is cleared
    if (core_in.irq_ack && irq_req_q) begin
      ack_onehot[vector_q] = 1'b1;
    end
  end

  assign group_clr = ack_onehot |
                     ((apb_wr && paddr == ADDR_GROUP_FLAG) ? pwdata[NUM_GROUPS-1:0] : '0);

  mfirq_flag_bank #(
    .W(NUM_GROUPS),
    .RST(RST_GROUP_FLAG)
  ) u_group_flags (
    .clk(pclk),
    .rst_n(presetn),
    .set(group_set),
    .clr(group_clr),
    .flags(group_req_flags_all),
    .rise(group_rise)
  );

  // ------------------------------------------------------------
  // Vector selection
  // ------------------------------------------------------------
  logic [VEC_W-1:0] vec_d;
  logic pend_any;

  always_comb begin
    vec_d = '0;
    pend_any = |group_pend;
    // R20: lowest group wins
    for (int g = NUM_GROUPS - 1; g >= 0; g--) begin
      if (group_pend[g]) begin
        vec_d = VEC_W'(g);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_q <= 1'b0;
    end else begin
      // R2: request drops at once after an ack
      irq_req_q <= pend_any & ~core_in.irq_ack;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_q <= '0;
    end else begin
      // R20: vector follows the winner
      vector_q <= vec_d;
    end
  end

  // ------------------------------------------------------------
  // Service entry
  // ------------------------------------------------------------

  // R13: entry pushes the program counter only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      push_pc_q <= 1'b0;
    end else begin
      push_pc_q <= core_in.irq_ack & irq_req_q;
    end
  end

  // ------------------------------------------------------------
  // Global enable
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable_q <= RST_GIE;
    end else if (core_in.irq_ack && irq_req_q) begin
      // R3: service clears global enable
      global_irq_enable_q <= 1'b0;
    end else if (core_in.return_from_irq_instr_exec) begin
      // R14: interrupt return re-enables
      global_irq_enable_q <= 1'b1;
    end else if (core_in.ret_exec) begin
      // R14: plain return keeps it
      global_irq_enable_q <= global_irq_enable_q;
    end else if (apb_wr && paddr == ADDR_CTRL) begin
      global_irq_enable_q <= pwdata[CTRL_GIE_BIT];
    end
  end

  // ------------------------------------------------------------
  // Enable registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_irq_en_q <= RST_GROUP_EN;
    end else if (apb_wr && paddr == ADDR_GROUP_EN) begin
      group_irq_en_q <= pwdata[NUM_GROUPS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_en_q <= RST_SRC_EN;
    end else if (apb_wr && paddr == ADDR_SRC_EN) begin
      // R7: one enable per existing flag
      src_en_q <= pwdata[NUM_SRC-1:0] & SRC_IMPL;
    end
  end

  // ------------------------------------------------------------
  // Wake-up
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
    end else begin
      // R9: any flag rising while halted
      // R10: enables play no part here
      wake_q <= core_in.halted & ((|src_rise) | (|group_rise));
    end
  end

  // ------------------------------------------------------------
  // Core outputs
  // ------------------------------------------------------------

  always_comb begin
    core_out.irq_req = irq_req_q;
    core_out.vector = vector_q;
    core_out.push_pc = push_pc_q;
    core_out.wakeup = wake_q;
    core_out.wake_service = wake_q & pend_any;
    // R19: disabled or stack full resumes after halt
    core_out.wake_resume_next = wake_q & ~pend_any;
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_comb begin
    prdata = '0;
    if (apb_rd) begin
      case (paddr)
        ADDR_CTRL: prdata[CTRL_GIE_BIT] = global_irq_enable_q;
        ADDR_GROUP_EN: prdata[NUM_GROUPS-1:0] = group_irq_en_q;
        ADDR_GROUP_FLAG: prdata[NUM_GROUPS-1:0] = group_req_flags_all;
        ADDR_SRC_FLAG: prdata[NUM_SRC-1:0] = src_flags;
        ADDR_SRC_EN: prdata[NUM_SRC-1:0] = src_en_q;
        ADDR_STATUS: begin
          prdata[STAT_REQ_BIT] = irq_req_q;
          prdata[STAT_VEC_LSB +: VEC_W] = vector_q;
          prdata[STAT_HALT_BIT] = core_in.halted;
        end
        default: prdata = '0;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: mfirq_checker.sv
`default_nettype none
module mfirq_checker
  import mfirq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire mfirq_pkg::mfirq_core_in_t core_in,
  input wire mfirq_pkg::mfirq_core_out_t core_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  stack_gate_a: assert property ($rose(core_out.irq_req) |-> $past(core_in.stack_free))
    else $error("request raised without stack space");
  ack_clears_a: assert property (core_in.irq_ack && core_out.irq_req |=>
    !core_out.irq_req && core_out.push_pc)
    else $error("acknowledge did not end request");
  push_cause_a: assert property (core_out.push_pc |->
    $past(core_in.irq_ack) && $past(core_out.irq_req))
    else $error("push without accepted acknowledge");
  push_single_a: assert property (core_out.push_pc |=> !core_out.push_pc)
    else $error("push longer than one cycle");
  vector_range_a: assert property (core_out.irq_req |-> core_out.vector < 3'h6)
    else $error("vector outside group range");
  wake_halt_a: assert property (core_out.wakeup |-> $past(core_in.halted))
    else $error("wakeup while running");
  wake_kind_a: assert property (core_out.wakeup |->
    core_out.wake_service ^ core_out.wake_resume_next)
    else $error("wakeup kind not exactly one");
  err_phase_a: assert property (pslverr |-> psel && penable && pready)
    else $error("error outside access phase");
  rdata_idle_a: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read access");
endmodule
`default_nettype wire

// file: mfirq_core_model.sv
`default_nettype none
module mfirq_core_model
  import mfirq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire mfirq_pkg::mfirq_core_out_t core_out,
  input wire logic [3:0] ack_wait,
  input wire logic stack_free,
  input wire logic halted,
  input wire logic return_from_irq_instr,
  input wire logic ret,
  output mfirq_pkg::mfirq_core_in_t core_in,
  output var int pushes,
  output logic [2:0] last_vec
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  logic ack_q;

  assign core_in = {stack_free, ack_q, return_from_irq_instr, ret, halted};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      ack_q <= 1'b0;
      pushes <= 0;
      last_vec <= 3'h0;
    end else begin
      ack_q <= 1'b0;
      if (core_out.push_pc) begin
        pushes <= pushes + 1;
      end
      if (core_out.irq_req && !ack_q) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q >= ack_wait) begin
          ack_q <= 1'b1;
          cnt_q <= 4'h0;
          last_vec <= core_out.vector;
        end
      end else begin
        cnt_q <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// file: multi_function_irq_sources_test.sv
`default_nettype none
module multi_function_irq_sources_test;
  timeunit 1ns;
  timeprecision 1ns;
  import mfirq_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin, lowdet;
  logic stack_free, halted, return_from_irq_instr, ret;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] ack_wait;
  logic [2:0] last_vec;
  mfirq_src_ev_t src_ev;
  mfirq_core_in_t core_in;
  mfirq_core_out_t core_out;
  int pushes;
  int wakes = 0;
  int resumes = 0;
  int services = 0;
  int mismatches = 0;
  int checks = 0;

  mfirq_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .periph_irq_pin(pin), .supply_low_det(lowdet), .src_ev, .core_in,
    .core_out);
  mfirq_core_model model_u (.pclk, .presetn, .core_out, .ack_wait, .stack_free, .halted,
    .return_from_irq_instr, .ret, .core_in, .pushes, .last_vec);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (core_out.wakeup === 1'b1) wakes++;
    if ((core_out.wakeup & core_out.wake_resume_next) === 1'b1) resumes++;
    if ((core_out.wakeup & core_out.wake_service) === 1'b1) services++;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk($sformatf("reg %h", a), x, r);
  endtask

  task automatic ev(input mfirq_src_ev_t s);
    src_ev <= s;
    @(posedge pclk);
    src_ev <= '0;
    @(posedge pclk);
  endtask

  task automatic do_return_from_irq_instr();
    return_from_irq_instr <= 1'b1;
    @(posedge pclk);
    return_from_irq_instr <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_push(input int t);
    int n;
    n = 0;
    while (pushes < t && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk("pushes", t, pushes);
  endtask

  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rdc(ADDR_CTRL, 32'h0);
    rdc(ADDR_GROUP_EN, 32'h0);
    rdc(ADDR_SRC_FLAG, 32'h0);
    wr(ADDR_SRC_EN, 32'hffff);
    rdc(ADDR_SRC_EN, 32'h6dff);
    wr(ADDR_SRC_SET, 32'h4);
    rdc(ADDR_SRC_FLAG, 32'h4);
    rdc(ADDR_GROUP_FLAG, 32'h2);
    wr(ADDR_SRC_FLAG, 32'h4);
    wr(ADDR_GROUP_FLAG, 32'h2);
    rdc(ADDR_GROUP_FLAG, 32'h0);
    apb(1'b0, 12'h0ff, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    $display("test regs done");
  endtask

  task automatic t_service();
    int p;
    p = pushes;
    wr(ADDR_SRC_EN, 32'h1);
    wr(ADDR_GROUP_EN, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    ev(14'h2000);
    wait_push(p + 1);
    chk("vector", 32'h0, {29'h0, last_vec});
    rdc(ADDR_GROUP_FLAG, 32'h0);
    rdc(ADDR_SRC_FLAG, 32'h1);
    rdc(ADDR_CTRL, 32'h0);
    ret <= 1'b1;
    @(posedge pclk);
    ret <= 1'b0;
    @(posedge pclk);
    rdc(ADDR_CTRL, 32'h0);
    do_return_from_irq_instr();
    rdc(ADDR_CTRL, 32'h1);
    wr(ADDR_SRC_FLAG, 32'h1);
    rdc(ADDR_SRC_FLAG, 32'h0);
    $display("test service done");
  endtask

  task automatic t_gate();
    int p;
    p = pushes;
    stack_free <= 1'b0;
    wr(ADDR_SRC_EN, 32'h2);
    wr(ADDR_GROUP_EN, 32'h1);
    pin <= 1'b0;
    repeat (8) @(posedge pclk);
    rdc(ADDR_SRC_FLAG, 32'h2);
    chk("irq_req", 32'h0, {31'h0, core_out.irq_req});
    stack_free <= 1'b1;
    wait_push(p + 1);
    chk("vector", 32'h0, {29'h0, last_vec});
    pin <= 1'b1;
    wr(ADDR_SRC_FLAG, 32'h2);
    $display("test gate done");
  endtask

  task automatic t_prio();
    int p;
    logic [2:0] vs [3] = '{3'h1, 3'h2, 3'h5};
    p = pushes;
    ack_wait <= 4'h5;
    lowdet <= 1'b1;
    ev(14'h1081);
    repeat (6) @(posedge pclk);
    rdc(ADDR_SRC_FLAG, 32'h404c);
    rdc(ADDR_GROUP_FLAG, 32'h26);
    wr(ADDR_SRC_EN, 32'hffff);
    wr(ADDR_GROUP_EN, 32'h3f);
    wr(ADDR_CTRL, 32'h1);
    for (int k = 0; k < 3; k++) begin
      wait_push(p + k + 1);
      chk("vector", {29'h0, vs[k]}, {29'h0, last_vec});
      do_return_from_irq_instr();
    end
    rdc(ADDR_GROUP_FLAG, 32'h0);
    lowdet <= 1'b0;
    ack_wait <= 4'h0;
    wr(ADDR_SRC_FLAG, 32'hffff);
    $display("test priority done");
  endtask

  task automatic t_wake();
    int w;
    int r;
    int p;
    int s;
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_SRC_EN, 32'h0);
    wr(ADDR_GROUP_EN, 32'h0);
    halted <= 1'b1;
    w = wakes;
    r = resumes;
    s = services;
    ev(14'h2000);
    repeat (3) @(posedge pclk);
    chk("wakes", w + 1, wakes);
    chk("resumes", r + 1, resumes);
    chk("services", s, services);
    ev(14'h2000);
    repeat (3) @(posedge pclk);
    chk("wakes", w + 1, wakes);
    wr(ADDR_SRC_FLAG, 32'h1);
    wr(ADDR_SRC_EN, 32'h1);
    wr(ADDR_GROUP_EN, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    p = pushes;
    ev(14'h2000);
    wait_push(p + 1);
    chk("wakes", w + 2, wakes);
    chk("resumes", r + 1, resumes);
    chk("services", s + 1, services);
    rdc(ADDR_STATUS, 32'h10);
    halted <= 1'b0;
    $display("test wake done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pin = 1'b1;
    lowdet = 1'b0;
    src_ev = '0;
    ack_wait = 4'h0;
    stack_free = 1'b1;
    halted = 1'b0;
    return_from_irq_instr = 1'b0;
    ret = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs();
    t_service();
    t_gate();
    t_prio();
    t_wake();
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    tally_and_finish();
  end
endmodule

bind mfirq_ctrl mfirq_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .core_in, .core_out);
`default_nettype wire
